/* wtc_pkg.sv */
// shared types and constants of the word and table comparator
package wtc_pkg;

	localparam int unsigned WORD_W     = 16;
	localparam int unsigned ADDR_W     = 16;
	localparam int unsigned IDX_W      = 4;
	// highest pair offset of a sixteen-word table
	localparam logic [3:0]  TABLE_LAST = 4'hF;
	// data memory size in words; indirect pointers must stay below it
	localparam logic [15:0] DM_WORDS   = 16'h03E8;
	localparam logic [3:0]  BCD_MAX    = 4'h9;
	// condition flag bit addresses in the special relay area
	localparam logic [15:0] ABOVE_BIT_ADDR = 16'h63A1;
	localparam logic [15:0] MATCH_BIT_ADDR = 16'h63A2;
	localparam logic [15:0] BELOW_BIT_ADDR = 16'h63A3;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [15:0] ADDR_RST   = 16'h0000;
	localparam logic [3:0]  IDX_RST    = 4'h0;

	typedef enum logic [1:0] {
		WTC_OP_NONE  = 2'b00,
		WTC_OP_WORD  = 2'b01,
		WTC_OP_MULTI = 2'b10
	} wtc_op_e;

	typedef enum logic [1:0] {
		WTC_ST_IDLE  = 2'b00,
		WTC_ST_RDA   = 2'b01,
		WTC_ST_RDB   = 2'b10,
		WTC_ST_CMP   = 2'b11
	} wtc_state_e;

	typedef struct packed {
		wtc_op_e             op;
		logic                exec;
		logic [1:0]          ind_used;
		logic [WORD_W-1:0]   ind_ptr0;
		logic [WORD_W-1:0]   ind_ptr1;
		logic [WORD_W-1:0]   first_operand;
		logic [WORD_W-1:0]   second_operand;
		logic [ADDR_W-1:0]   first_table_base;
		logic [ADDR_W-1:0]   first_area_end;
		logic [ADDR_W-1:0]   second_table_base;
		logic [ADDR_W-1:0]   second_area_end;
	} wtc_req_s;

	typedef struct packed {
		logic above_flag;
		logic match_flag;
		logic below_flag;
	} wtc_flags_s;

	typedef struct packed {
		wtc_state_e          st;
		logic [IDX_W-1:0]    idx;
		logic [ADDR_W-1:0]   tb1;
		logic [ADDR_W-1:0]   tb2;
		logic [WORD_W-1:0]   word_a;
		logic [WORD_W-1:0]   mask;
		logic [ADDR_W-1:0]   mem_addr;
		logic                mem_rd;
		logic                res_we;
		logic [WORD_W-1:0]   res_data;
		wtc_flags_s          flags;
		logic                fault;
		logic                done;
		logic                busy;
	} wtc_state_s;

endpackage

/* wtc_comparator.sv */
// word compare and sixteen-pair table compare datapath
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RULE1] With its execution condition off the table compare reads nothing and writes no result.
// [RULE2] An enabled table compare checks first table word i against second table word i for i from 0 to 15.
// [RULE3] A matching pair clears the result bit whose position is the pair offset.
// [RULE4] A differing pair sets its result bit, giving a 16-bit inequality mask.
// [RULE5] The fault flag rises when either sixteen-word table would run past the end of its data area.
// [RULE6] Both operations raise the fault flag for an indirect pointer that is not BCD or lies past data memory.
// [RULE7] With its execution condition off the word compare evaluates nothing and leaves all flags alone.
// [RULE8] An enabled word compare compares the two operands and updates the above, match and below flags.
// [RULE9] The above flag is on exactly when the first operand is larger.
// [RULE10] The match flag is on exactly when the two operands are equal.
// [RULE11] The below flag is on exactly when the first operand is smaller, so one flag alone is on.
// [RULE12] Software must give values compared against a timer or counter present value in BCD.
// [RULE13] Software should read the three flags before any later instruction can overwrite them.
// [RULE14] Operands are 16-bit unsigned, equal only when all bits match and ordered by binary magnitude.
// [RULE15] A faulting operation writes neither the result word nor the condition flags.
module wtc_comparator (
	input  wire logic                        CLK_I,
	input  wire logic                        NRST_I,
	input  wire logic                        START_I,
	input  wire wtc_pkg::wtc_req_s           REQ_I,
	input  wire logic [wtc_pkg::WORD_W-1:0]  MEM_DATA_I,
	output logic                             BUSY_O,
	output logic                             DONE_O,
	output logic                             MEM_RD_O,
	output logic [wtc_pkg::ADDR_W-1:0]       MEM_ADDR_O,
	output logic                             RES_WE_O,
	output logic [wtc_pkg::WORD_W-1:0]       RES_DATA_O,
	output wtc_pkg::wtc_flags_s              FLAGS_O,
	output logic                             FAULT_O
);

	////////////////////////////////////////////////////////////////////////////
	// pointer checks

	function automatic logic ptr_bad(input logic [15:0] p);
		logic [15:0] val;
		logic        nbcd;
		val  = 16'h0000;
		nbcd = 1'b0;
		for (int k = 3; k >= 0; k--) begin
			if (p[k*4 +: 4] > wtc_pkg::BCD_MAX) begin
				nbcd = 1'b1;
			end
			val = 16'((val * 16'h000A) + {12'h000, p[k*4 +: 4]});
		end
		return nbcd || (val >= wtc_pkg::DM_WORDS);
	endfunction

	wtc_pkg::wtc_state_s s_q;
	wtc_pkg::wtc_state_s s_d;

	logic        ind_fault;
	logic        tbl_fault;
	logic [16:0] tb1_last;
	logic [16:0] tb2_last;
	logic        pair_differs;

	// [RULE6] indirect pointer check
	assign ind_fault = (REQ_I.ind_used[0] && ptr_bad(REQ_I.ind_ptr0)) ||
	                   (REQ_I.ind_used[1] && ptr_bad(REQ_I.ind_ptr1));

	// wide sums so a base near the top of the map cannot wrap past the check
	assign tb1_last = {1'b0, REQ_I.first_table_base} + {13'h0000, wtc_pkg::TABLE_LAST};
	assign tb2_last = {1'b0, REQ_I.second_table_base} + {13'h0000, wtc_pkg::TABLE_LAST};

	// [RULE5] table overrun check
	assign tbl_fault = (tb1_last > {1'b0, REQ_I.first_area_end}) ||
	                   (tb2_last > {1'b0, REQ_I.second_area_end});

	// [RULE14] raw 16-bit equality
	assign pair_differs = (s_q.word_a != MEM_DATA_I);

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d        = s_q;
		s_d.done   = 1'b0;
		s_d.res_we = 1'b0;
		s_d.mem_rd = 1'b0;
		case (s_q.st)
			wtc_pkg::WTC_ST_IDLE: begin
				if (START_I) begin
					s_d.done = 1'b1;
					case (REQ_I.op)
						wtc_pkg::WTC_OP_WORD: begin
							// [RULE7] skipped when off
							if (REQ_I.exec) begin
								if (ind_fault) begin
									// [RULE15] flags kept on fault
									s_d.fault = 1'b1;
								end else begin
									s_d.fault = 1'b0;
									// [RULE8] [RULE14] unsigned compare
									// [RULE9] above flag
									s_d.flags.above_flag = REQ_I.first_operand > REQ_I.second_operand;
									// [RULE10] match flag
									s_d.flags.match_flag = REQ_I.first_operand == REQ_I.second_operand;
									// [RULE11] below flag
									s_d.flags.below_flag = REQ_I.first_operand < REQ_I.second_operand;
								end
							end
						end
						wtc_pkg::WTC_OP_MULTI: begin
							// [RULE1] nothing read or written when off
							if (REQ_I.exec) begin
								if (ind_fault || tbl_fault) begin
									// [RULE15] result untouched on fault
									s_d.fault = 1'b1;
								end else begin
									s_d.fault    = 1'b0;
									s_d.done     = 1'b0;
									s_d.busy     = 1'b1;
									s_d.idx      = wtc_pkg::IDX_RST;
									s_d.tb1      = REQ_I.first_table_base;
									s_d.tb2      = REQ_I.second_table_base;
									s_d.mask     = wtc_pkg::RESULT_RST;
									s_d.mem_rd   = 1'b1;
									s_d.mem_addr = REQ_I.first_table_base;
									s_d.st       = wtc_pkg::WTC_ST_RDA;
								end
							end
						end
						default: begin
							s_d.done = 1'b1;
						end
					endcase
				end
			end
			wtc_pkg::WTC_ST_RDA: begin
				// [RULE2] second table word of this pair
				s_d.mem_rd   = 1'b1;
				s_d.mem_addr = 16'(s_q.tb2 + {12'h000, s_q.idx});
				s_d.st       = wtc_pkg::WTC_ST_RDB;
			end
			wtc_pkg::WTC_ST_RDB: begin
				// first table word arrives now
				s_d.word_a = MEM_DATA_I;
				s_d.st     = wtc_pkg::WTC_ST_CMP;
			end
			wtc_pkg::WTC_ST_CMP: begin
				// [RULE3] [RULE4] mask bit at pair offset
				s_d.mask[s_q.idx] = pair_differs;
				if (s_q.idx == wtc_pkg::TABLE_LAST) begin
					s_d.res_we   = 1'b1;
					s_d.res_data = s_d.mask;
					s_d.done     = 1'b1;
					s_d.busy     = 1'b0;
					s_d.st       = wtc_pkg::WTC_ST_IDLE;
				end else begin
					// [RULE2] next pair
					s_d.idx      = 4'(s_q.idx + 4'h1);
					s_d.mem_rd   = 1'b1;
					s_d.mem_addr = 16'(s_q.tb1 + {12'h000, 4'(s_q.idx + 4'h1)});
					s_d.st       = wtc_pkg::WTC_ST_RDA;
				end
			end
			default: begin
				s_d.st   = wtc_pkg::WTC_ST_IDLE;
				s_d.busy = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			s_q.st       <= wtc_pkg::WTC_ST_IDLE;
			s_q.idx      <= wtc_pkg::IDX_RST;
			s_q.tb1      <= wtc_pkg::ADDR_RST;
			s_q.tb2      <= wtc_pkg::ADDR_RST;
			s_q.word_a   <= wtc_pkg::RESULT_RST;
			s_q.mask     <= wtc_pkg::RESULT_RST;
			s_q.mem_addr <= wtc_pkg::ADDR_RST;
			s_q.mem_rd   <= 1'b0;
			s_q.res_we   <= 1'b0;
			s_q.res_data <= wtc_pkg::RESULT_RST;
			s_q.flags    <= '0;
			s_q.fault    <= 1'b0;
			s_q.done     <= 1'b0;
			s_q.busy     <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register

	assign BUSY_O     = s_q.busy;
	assign DONE_O     = s_q.done;
	assign MEM_RD_O   = s_q.mem_rd;
	assign MEM_ADDR_O = s_q.mem_addr;
	assign RES_WE_O   = s_q.res_we;
	assign RES_DATA_O = s_q.res_data;
	// flags hold until the next executed word compare without a pointer fault overwrites them
	assign FLAGS_O    = s_q.flags;
	assign FAULT_O    = s_q.fault;

endmodule

/* wtc_comparator_assertions.sv */
// concurrent checks on the comparator ports
module wtc_chk (
	input wire logic                       CLK_I,
	input wire logic                       NRST_I,
	input wire logic                       START_I,
	input wire wtc_pkg::wtc_req_s          REQ_I,
	input wire logic [wtc_pkg::WORD_W-1:0] MEM_DATA_I,
	input wire logic                       BUSY_O,
	input wire logic                       DONE_O,
	input wire logic                       MEM_RD_O,
	input wire logic [wtc_pkg::ADDR_W-1:0] MEM_ADDR_O,
	input wire logic                       RES_WE_O,
	input wire logic [wtc_pkg::WORD_W-1:0] RES_DATA_O,
	input wire wtc_pkg::wtc_flags_s        FLAGS_O,
	input wire logic                       FAULT_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	wtc_pkg::wtc_req_s q;
	logic tk, wd, tb, lim, bad0;
	assign tk = START_I && !BUSY_O && REQ_I.exec;
	assign wd = tk && REQ_I.op == wtc_pkg::WTC_OP_WORD;
	assign tb = tk && REQ_I.op == wtc_pkg::WTC_OP_MULTI;
	assign lim = {1'b0, REQ_I.first_table_base} + 17'h0000F > {1'b0, REQ_I.first_area_end}
		|| {1'b0, REQ_I.second_table_base} + 17'h0000F > {1'b0, REQ_I.second_area_end};
	// pointer of 1000 or more, or with a non-decimal digit
	assign bad0 = REQ_I.ind_ptr0[15:12] != 4'h0 || REQ_I.ind_ptr0[11:8] > wtc_pkg::BCD_MAX
		|| REQ_I.ind_ptr0[7:4] > wtc_pkg::BCD_MAX || REQ_I.ind_ptr0[3:0] > wtc_pkg::BCD_MAX;
	always_ff @(posedge CLK_I) q <= REQ_I;
	a_word_above: assert property (wd && REQ_I.ind_used == 2'h0 |=> DONE_O
		&& FLAGS_O.above_flag == (q.first_operand > q.second_operand)) else $error("above flag wrong");
	a_word_match: assert property (wd && REQ_I.ind_used == 2'h0 |=> DONE_O
		&& FLAGS_O.match_flag == (q.first_operand == q.second_operand)) else $error("match flag wrong");
	a_word_below: assert property (wd && REQ_I.ind_used == 2'h0 |=> DONE_O
		&& FLAGS_O.below_flag == (q.first_operand < q.second_operand)) else $error("below flag wrong");
	a_exec_off: assert property (START_I && !BUSY_O && !REQ_I.exec |=> DONE_O && !RES_WE_O
		&& $stable(FLAGS_O) && $stable(FAULT_O)) else $error("disabled op changed state");
	// done is launched by the 48th edge after the take, so it is sampled one edge later
	a_table_span: assert property (tb && !lim && REQ_I.ind_used == 2'h0 |-> ##1 BUSY_O ##48 DONE_O && RES_WE_O)
		else $error("table compare length wrong");
	a_table_fault: assert property (tb && lim |=> FAULT_O && DONE_O && !RES_WE_O && !MEM_RD_O)
		else $error("table overrun not refused");
	a_ptr_fault: assert property (wd && REQ_I.ind_used[0] && bad0 |=> FAULT_O && $stable(FLAGS_O))
		else $error("bad pointer not refused");
	a_read_pair: assert property ($rose(MEM_RD_O) |=> MEM_RD_O ##1 !MEM_RD_O)
		else $error("read strobes not paired");
endmodule
bind wtc_comparator wtc_chk u_chk (.CLK_I(CLK_I), .NRST_I(NRST_I), .START_I(START_I), .REQ_I(REQ_I),
	.MEM_DATA_I(MEM_DATA_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .MEM_RD_O(MEM_RD_O), .MEM_ADDR_O(MEM_ADDR_O),
	.RES_WE_O(RES_WE_O), .RES_DATA_O(RES_DATA_O), .FLAGS_O(FLAGS_O), .FAULT_O(FAULT_O));

/* wtc_mem_model.sv */
// data memory model answering the comparator reads
module wtc_mem_model (
	input  wire logic        clk_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] diff_i,
	output logic      [15:0] data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial data_o = 16'h0000;
	always @(posedge clk_i) begin
		if (rd_i) begin
			data_o <= {4{addr_i[3:0]}} ^ ((addr_i[8] && diff_i[addr_i[3:0]]) ? 16'h0100 : 16'h0000);
		end else begin
			// stale word scrambled so a late capture cannot pass
			data_o <= ~data_o;
		end
	end
endmodule

/* test_word_and_table_comparator.sv */
// self-checking bench for the word and table comparator
module test_word_and_table_comparator;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {wtc_pkg::wtc_flags_s f; logic e; logic w; logic [15:0] m;} wtc_exp_s;
	logic              CLK_I = 1'b0, NRST_I = 1'b0, START_I = 1'b0, BUSY_O, DONE_O, MEM_RD_O, RES_WE_O, FAULT_O;
	logic       [15:0] MEM_DATA_I, MEM_ADDR_O, RES_DATA_O, diff = 16'h0000, lf = 16'h9397;
	wtc_pkg::wtc_req_s REQ_I = '0;
	wtc_pkg::wtc_flags_s FLAGS_O;
	wtc_exp_s          cur = '0, got, expq[$];
	int                mismatches = 0, total_checks = 0;
	always #5 CLK_I = ~CLK_I;
	wtc_comparator DUT (.CLK_I(CLK_I), .NRST_I(NRST_I), .START_I(START_I), .REQ_I(REQ_I), .MEM_DATA_I(MEM_DATA_I),
		.BUSY_O(BUSY_O), .DONE_O(DONE_O), .MEM_RD_O(MEM_RD_O), .MEM_ADDR_O(MEM_ADDR_O), .RES_WE_O(RES_WE_O),
		.RES_DATA_O(RES_DATA_O), .FLAGS_O(FLAGS_O), .FAULT_O(FAULT_O));
	wtc_mem_model u_mem (.clk_i(CLK_I), .rd_i(MEM_RD_O), .addr_i(MEM_ADDR_O), .diff_i(diff), .data_o(MEM_DATA_I));
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic bad(input logic [15:0] p);
		bad = p[15:12] != 4'h0 || p[11:8] > 4'h9 || p[7:4] > 4'h9 || p[3:0] > 4'h9;
	endfunction
	task automatic fail(input string s);
		mismatches++;
		$display("ERROR %0t %s", $time, s);
	endtask
	task automatic complete_run();
		if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic issue(input wtc_pkg::wtc_req_s r);
		logic flt;
		flt = (r.ind_used[0] && bad(r.ind_ptr0)) || (r.ind_used[1] && bad(r.ind_ptr1));
		if (r.op == wtc_pkg::WTC_OP_MULTI)
			flt |= {1'b0, r.first_table_base} + 17'h0000F > {1'b0, r.first_area_end}
				|| {1'b0, r.second_table_base} + 17'h0000F > {1'b0, r.second_area_end};
		cur.w = 1'b0;
		if (r.exec && (r.op == wtc_pkg::WTC_OP_WORD || r.op == wtc_pkg::WTC_OP_MULTI)) begin
			cur.e = flt;
			if (!flt && r.op == wtc_pkg::WTC_OP_WORD) begin
				cur.f = {r.first_operand > r.second_operand, r.first_operand == r.second_operand,
					r.first_operand < r.second_operand};
			end
			cur.w = !flt && r.op == wtc_pkg::WTC_OP_MULTI;
			cur.m = diff;
		end
		expq.push_back(cur);
		@(posedge CLK_I);
		START_I <= 1'b1;
		REQ_I <= r;
	endtask
	task automatic idle();
		int n;
		@(posedge CLK_I);
		START_I <= 1'b0;
		for (n = 0; n < 60 && (BUSY_O !== 1'b0 || expq.size() != 0); n++) @(posedge CLK_I);
		if (n == 60) begin
			fail("no answer");
			complete_run();
		end
	endtask
	// results read at the done cycle, before any later request
	always @(negedge CLK_I) begin
		if (DONE_O === 1'b1) begin
			if (expq.size() == 0) fail("unexpected done");
			else begin
				got = expq.pop_front();
				total_checks++;
				if ({FLAGS_O, FAULT_O, RES_WE_O} !== {got.f, got.e, got.w} || (got.w && RES_DATA_O !== got.m))
					fail("result differs");
			end
		end
	end
	initial begin
		wtc_pkg::wtc_req_s r;
		int k;
		repeat (3) @(posedge CLK_I);
		NRST_I <= 1'b1;
		r = '0;
		r.op = wtc_pkg::WTC_OP_WORD;
		r.exec = 1'b1;
		{r.first_operand, r.second_operand} = {16'h4000, 16'h3999};
		issue(r);
		{r.first_operand, r.second_operand} = {16'hFFFF, 16'h0000};
		issue(r);
		for (k = 0; k < 40; k++) begin
			lf = lfsr_next(lf);
			// WTC_OP_NONE and the undefined code 2'b11 both go through the decoder's default branch
			r.op = (lf[6] && lf[7]) ? wtc_pkg::wtc_op_e'({2{lf[8]}}) : wtc_pkg::WTC_OP_WORD;
			r.exec = lf[0] | lf[1];
			r.ind_used = lf[3:2] & {2{lf[4]}};
			r.ind_ptr0 = lf ^ 16'h5A5A;
			r.ind_ptr1 = lf & 16'h0999;
			r.first_operand = lf;
			r.second_operand = lf[5] ? lf : {lf[7:0], lf[15:8]};
			issue(r);
		end
		idle();
		for (k = 0; k < 6; k++) begin
			r = '0;
			r.op = wtc_pkg::WTC_OP_MULTI;
			r.exec = k != 2;
			{r.first_table_base, r.first_area_end} = {16'h0010, k == 1 ? 16'h001E : 16'h001F};
			{r.second_table_base, r.second_area_end} = {16'h0120, k == 3 ? 16'h012E : 16'h0FFF};
			{r.ind_used, r.ind_ptr1} = {k == 4 ? 2'h2 : 2'h0, 16'h1000};
			lf = lfsr_next(lf);
			diff = lf;
			issue(r);
			idle();
		end
		complete_run();
	end
endmodule
